// ==== rtl/dram_host.sv ====
/*
 * Host controller for a 256K x 4 multiplexed-address dynamic RAM.
 * Assumes the DRAM pins are wired straight to the ports; the data pins
 * are resolved by the testbench from data_oe_n.
 */
// Summary of operation
// RULE1 - Row address then column address driven on the shared address pins.
// RULE2 - Address held stable before and across each strobe fall.
// RULE3 - Device latches are transparent; column address follows row hold time.
// RULE4 - Write enable low selects a write, high selects a read.
// RULE5 - Device ignores data pins during read cycles.
// RULE6 - Write data latched on later fall of write enable or column strobe.
// RULE7 - Early write: write enable falls before column strobe.
// RULE8 - Delayed write: write enable falls after column strobe.
// RULE9 - Device output stays high impedance until column strobe falls.
// RULE10 - Read data valid within row, column, address or enable access time.
// RULE11 - Read data held until column strobe or output enable rises.
// RULE12 - Early write keeps device outputs high impedance all cycle.
// RULE13 - All 512 rows refreshed within every 64 ms.
// RULE14 - Column strobe falls at least 20 ns after row strobe.
// RULE15 - Column strobe precharged 20 ns before column-before-row refresh.
// RULE16 - Read data ready 70 ns after row strobe fall.
// RULE17 - Row-only refresh keeps column strobe high throughout.
// RULE18 - Column-before-row refresh uses the device's internal row counter.
// RULE19 - After power-up wait 200 us, then eight refreshes before access.
// RULE20 - Refreshes spread evenly; accesses wait while a refresh runs.
`timescale 1ns/10ps
`include "dram_host_params.svh"
module dram_host #(
	parameter int POWERUP_CYCLES = `CYC_POWERUP,
	parameter int REFRESH_INTERVAL = `CYC_REFRESH_INTERVAL
) (
	input wire logic clk, // 250 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic req_valid, // Access request
	output logic req_ready, // Request taken this cycle
	input wire logic req_write, // 1 write, 0 read
	input wire logic [17:0] req_addr, // Row in [17:9], column in [8:0]
	input wire dram_host_pkg::nibble_t req_wdata, // Write data
	output dram_host_pkg::nibble_t rd_data, // Read data
	output logic rd_valid, // One-cycle pulse with rd_data
	output logic init_done, // Power-up sequence finished
	output logic [`ADDR_PINS-1:0] mux_addr, // Multiplexed address pins
	output logic row_strobe_n, // Row strobe
	output logic col_strobe_n, // Column strobe
	output logic write_enable_n, // Write enable
	output logic output_enable_n, // Output enable
	input wire dram_host_pkg::nibble_t data_in, // Data pins, input side
	output dram_host_pkg::nibble_t data_out, // Data pins, output side
	output logic data_oe_n // Data pins drive enable, low drives
);
	import dram_host_pkg::*;

	localparam int TW = 24;

	host_state_t state_ff, nxt_state;
	logic [TW-1:0] ref_cnt_ff;
	logic ref_pend_ff;
	logic pu_loaded_ff;
	logic [3:0] init_cnt_ff;
	logic write_ff;
	logic [17:0] addr_ff;
	nibble_t wdata_ff;
	nibble_t din_s1_ff, din_s2_ff;
	logic t_load;
	logic [TW-1:0] t_count;
	logic t_done;

	cycle_timer #(.WIDTH(TW)) u_timer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.load(t_load),
		.count(t_count),
		.done(t_done)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire idle_now = (state_ff == ST_IDLE);
	wire do_refresh = idle_now && ref_pend_ff;
	// Refresh always wins over a waiting access
	assign req_ready = ce && idle_now && !ref_pend_ff && init_done; // RULE20
	wire take_req = req_ready && req_valid;
	wire ref_tick = (ref_cnt_ff == '0);
	// Power-up pause is loaded on the first enabled cycle after reset
	wire pu_kick = (state_ff == ST_POWERUP) && !pu_loaded_ff;
	wire [TW-1:0] pu_count = TW'(POWERUP_CYCLES);
	// Timer still reads zero in the cycle it is kicked
	wire t_expired = t_done && !pu_kick;

	// ----------------------------------------
	// Refresh scheduler
	// ----------------------------------------
	// One refresh per interval spreads all rows over the period
	always_ff @(posedge clk)
	begin
		if (rst)
			ref_cnt_ff <= '0;
		else if (ce)
			ref_cnt_ff <= ref_tick ? TW'(REFRESH_INTERVAL - 1) : ref_cnt_ff - 1'b1; // RULE13
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			ref_pend_ff <= 1'b0;
		else if (ce && ref_tick && state_ff != ST_POWERUP)
			ref_pend_ff <= 1'b1; // RULE20
		else if (ce && do_refresh)
			ref_pend_ff <= 1'b0;
	end

	// Init needs eight refreshes; they are forced back to back
	always_ff @(posedge clk)
	begin
		if (rst)
			init_cnt_ff <= 4'h0;
		else if (ce && state_ff == ST_CBR_END && t_expired && !init_done)
			init_cnt_ff <= init_cnt_ff + 4'h1; // RULE19
	end
	assign init_done = (init_cnt_ff == 4'(`INIT_REFRESHES));

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		t_load = 1'b0;
		t_count = '0;
		case (state_ff)
			ST_POWERUP:
			begin
				t_load = pu_kick; // RULE19
				t_count = pu_count;
				if (t_expired)
					nxt_state = ST_IDLE; // RULE19
			end
			ST_IDLE:
				if (do_refresh || !init_done)
				begin
					nxt_state = ST_CBR_SETUP; // RULE15
					t_load = 1'b1;
					t_count = TW'(`CYC_CBR_PRE);
				end
				else if (take_req)
				begin
					nxt_state = ST_ROW;
					t_load = 1'b1;
					t_count = TW'(`CYC_ROW_HOLD);
				end
			ST_ROW:
				if (t_expired)
				begin
					nxt_state = ST_RCD;
					t_load = 1'b1;
					t_count = TW'(`CYC_RCD - `CYC_ROW_HOLD); // RULE14
				end
			ST_RCD:
				if (t_expired)
				begin
					nxt_state = ST_COL;
					t_load = 1'b1;
					t_count = TW'(`CYC_RAC - `CYC_RCD); // RULE16
				end
			ST_COL:
				if (t_expired)
				begin
					nxt_state = ST_PRE;
					t_load = 1'b1;
					t_count = TW'(`CYC_ROW_PRE);
				end
			ST_PRE:
				if (t_expired)
					nxt_state = ST_IDLE;
			ST_CBR_SETUP:
				if (t_expired)
				begin
					nxt_state = ST_CBR_ROW;
					t_load = 1'b1;
					t_count = TW'(`CYC_ROW_LOW);
				end
			ST_CBR_ROW:
				if (t_expired)
				begin
					nxt_state = ST_CBR_END;
					t_load = 1'b1;
					t_count = TW'(`CYC_ROW_PRE);
				end
			ST_CBR_END:
				if (t_expired)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_ff <= ST_POWERUP;
		else if (ce)
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pu_loaded_ff <= 1'b0;
		else if (ce)
			pu_loaded_ff <= 1'b1;
	end

	// ----------------------------------------
	// Request capture
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			write_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= 4'h0;
		end
		else if (ce && take_req)
		begin
			write_ff <= req_write;
			addr_ff <= req_addr;
			wdata_ff <= req_wdata;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	wire in_access = (state_ff == ST_ROW) || (state_ff == ST_RCD) || (state_ff == ST_COL);
	wire col_phase = (state_ff == ST_RCD) || (state_ff == ST_COL);
	wire cbr_col_low = (state_ff == ST_CBR_ROW);
	wire [`ADDR_PINS-1:0] addr_sel = col_phase ? addr_ff[8:0] : addr_ff[17:9]; // RULE1 RULE3
	// Row leaves with the take, a cycle ahead of the row strobe
	wire [`ADDR_PINS-1:0] addr_pick = take_req ? req_addr[17:9] : addr_sel; // RULE2

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			row_strobe_n <= 1'b1;
			col_strobe_n <= 1'b1;
			mux_addr <= '0;
			write_enable_n <= 1'b1;
			output_enable_n <= 1'b1;
			data_out <= 4'h0;
			data_oe_n <= 1'b1;
		end
		else if (ce)
		begin
			// Address registered one cycle ahead of the row strobe fall and three cycles ahead of the column strobe fall
			mux_addr <= addr_pick; // RULE2
			row_strobe_n <= !(in_access || cbr_col_low); // RULE18
			col_strobe_n <= !((state_ff == ST_COL) || (state_ff == ST_CBR_SETUP && t_expired)
				|| cbr_col_low); // RULE15 RULE18
			write_enable_n <= !(write_ff && in_access && state_ff != ST_ROW); // RULE4 RULE7 RULE8
			output_enable_n <= !(!write_ff && state_ff == ST_COL); // RULE5 RULE11
			data_out <= wdata_ff;
			data_oe_n <= !(write_ff && in_access); // RULE12 RULE17
		end
	end

	// Read data sampled through two flops just before strobes rise
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			din_s1_ff <= 4'h0;
			din_s2_ff <= 4'h0;
			rd_data <= 4'h0;
			rd_valid <= 1'b0;
		end
		else if (ce)
		begin
			din_s1_ff <= data_in;
			din_s2_ff <= din_s1_ff;
			rd_valid <= 1'b0;
			if (state_ff == ST_COL && t_expired && !write_ff)
			begin
				rd_data <= din_s2_ff; // RULE9 RULE10
				rd_valid <= 1'b1;
			end
		end
	end

endmodule

// ==== rtl/dram_host_params.svh ====
/*
 * Timing constants and pin widths for the page mode DRAM host controller.
 * Assumes a 250 MHz clock (4 ns period); counts derive from ns figures.
 */
`ifndef DRAM_HOST_PARAMS_SVH
`define DRAM_HOST_PARAMS_SVH

`define CLK_PERIOD_PS 4000
`define ADDR_PINS 9
`define DATA_PINS 4
`define REFRESH_ROWS 512
`define INIT_REFRESHES 8

// Times in their own units, as printed
`define REFRESH_PERIOD_MS 64
`define POWERUP_PAUSE_US 200
`define ROW_STROBE_LOW_NS 70
`define ROW_PRECHARGE_NS 60
`define ROW_ADDR_HOLD_NS 10
`define ROW_TO_COL_DELAY_NS 20
`define COL_STROBE_LOW_NS 20
`define ACCESS_FROM_ROW_NS 70
`define CBR_COL_PRECHARGE_NS 20
`define CBR_COL_HOLD_NS 10
`define DATA_HOLD_NS 10

// Least times round up, longest times round down
`define CYC_UP(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_ROW_LOW `CYC_UP(`ROW_STROBE_LOW_NS)
`define CYC_ROW_PRE `CYC_UP(`ROW_PRECHARGE_NS)
`define CYC_ROW_HOLD `CYC_UP(`ROW_ADDR_HOLD_NS)
`define CYC_RCD `CYC_UP(`ROW_TO_COL_DELAY_NS)
`define CYC_COL_LOW `CYC_UP(`COL_STROBE_LOW_NS)
`define CYC_RAC `CYC_UP(`ACCESS_FROM_ROW_NS)
`define CYC_CBR_PRE `CYC_UP(`CBR_COL_PRECHARGE_NS)
`define CYC_CBR_HOLD `CYC_UP(`CBR_COL_HOLD_NS)
`define CYC_DATA_HOLD `CYC_UP(`DATA_HOLD_NS)
// Worked in ns so the products stay inside 32 bits
`define CYC_REFRESH_INTERVAL \
	(((`REFRESH_PERIOD_MS * 1000000) / (`CLK_PERIOD_PS / 1000)) / `REFRESH_ROWS)
`define CYC_POWERUP (((`POWERUP_PAUSE_US * 1000000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== rtl/dram_host_pkg.sv ====
/*
 * Types shared by the DRAM host controller files.
 * Assumes dram_host_params.svh supplies all numbers.
 */
package dram_host_pkg;
	typedef enum logic [3:0] {
		ST_POWERUP,
		ST_IDLE,
		ST_ROW,
		ST_RCD,
		ST_COL,
		ST_PRE,
		ST_CBR_SETUP,
		ST_CBR_ROW,
		ST_CBR_END
	} host_state_t;
	typedef logic [3:0] nibble_t;
endpackage

// ==== rtl/cycle_timer.sv ====
/*
 * Load-and-count-down timer used for every strobe interval.
 * Assumes a synchronous, active-high reset and a shared clock enable.
 */
`timescale 1ns/10ps
module cycle_timer #(
	parameter int WIDTH = 24
) (
	input wire logic clk, // Clock
	input wire logic rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic load, // Load new count
	input wire logic [WIDTH-1:0] count, // Cycles to wait
	output logic done // Count has run out
);
	logic [WIDTH-1:0] cnt_ff;

	assign done = (cnt_ff == '0);

	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_ff <= '0;
		else if (ce && load)
			cnt_ff <= count;
		else if (ce && !done)
			cnt_ff <= cnt_ff - 1'b1;
	end
endmodule

// ==== testbench/dram_host_chk.sv ====
/* Pin timing checker for dram_host.
 * Bound to dram_host; sees its ports only; ce held high. */
`timescale 1ns/10ps
`include "dram_host_params.svh"
module dram_host_chk #(
	parameter int POWERUP_CYCLES = 20,
	parameter int REFRESH_INTERVAL = 200
) (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic req_ready, // Ready
	input wire logic init_done, // Init done
	input wire logic rd_valid, // Read pulse
	input wire logic [`ADDR_PINS-1:0] mux_addr, // Address
	input wire logic row_strobe_n, // Row
	input wire logic col_strobe_n, // Column
	input wire logic write_enable_n, // Write
	input wire logic output_enable_n, // Enable
	input wire logic data_oe_n // Drive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic row_q_ff;
	int gap_ff;
	int since_rst_ff;
	// ----------------
	// Refresh spacing
	// ----------------
	always_ff @(posedge clk)
	begin
		row_q_ff <= row_strobe_n;
		if (rst || (row_q_ff && !row_strobe_n && !col_strobe_n))
			gap_ff <= 0;
		else
			gap_ff <= gap_ff + 1;
	end
	a_refresh_gap: assert property (init_done |-> gap_ff < REFRESH_INTERVAL + 64)
		else $error("refresh late");
	a_ready_init: assert property (req_ready |-> init_done)
		else $error("ready before init");
	a_ready_idle: assert property (req_ready |-> row_strobe_n && col_strobe_n)
		else $error("ready while busy");
	a_row_hold: assert property ($fell(row_strobe_n) && col_strobe_n |->
		$stable(mux_addr) ##1 $stable(mux_addr)[*2]) else $error("row address moved");
	a_col_stable: assert property ($fell(col_strobe_n) && !row_strobe_n |->
		$stable(mux_addr)) else $error("column address moved");
	a_row_to_col: assert property ($fell(col_strobe_n) && !row_strobe_n |->
		!$past(row_strobe_n, 5)) else $error("column too soon");
	a_cbr_pre: assert property ($fell(col_strobe_n) && row_strobe_n |->
		$past(col_strobe_n, 5)) else $error("short precharge");
	a_early_wr: assert property ($fell(col_strobe_n) && !write_enable_n |->
		!$past(write_enable_n) && !data_oe_n) else $error("late write");
	a_no_clash: assert property (!output_enable_n |-> write_enable_n && data_oe_n)
		else $error("drive clash");
	a_row_width: assert property ($rose(row_strobe_n) |-> !$past(row_strobe_n, 18))
		else $error("row strobe short");
	a_rd_pulse: assert property (rd_valid |=> !rd_valid)
		else $error("read pulse long");
	// Cycles since reset, saturating once the pause is over
	always_ff @(posedge clk)
	begin
		if (rst)
			since_rst_ff <= 0;
		else if (since_rst_ff <= POWERUP_CYCLES)
			since_rst_ff <= since_rst_ff + 1;
	end
	a_pause_held: assert property (since_rst_ff < POWERUP_CYCLES |->
		row_strobe_n && col_strobe_n) else $error("strobe during power-up pause");
endmodule
bind dram_host dram_host_chk #(.POWERUP_CYCLES(POWERUP_CYCLES),
	.REFRESH_INTERVAL(REFRESH_INTERVAL)) chk_u (.clk(clk), .rst(rst),
	.req_ready(req_ready), .init_done(init_done), .rd_valid(rd_valid),
	.mux_addr(mux_addr), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
	.write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
	.data_oe_n(data_oe_n));

// ==== testbench/dram_dev_model.sv ====
/* Behavioural 256K x 4 DRAM.
 * The bench resolves the data pins; dq_in is the wire level. */
`timescale 1ns/10ps
module dram_dev_model #(
	parameter real ACC_NS = 16.0
) (
	input wire logic [8:0] mux_addr, // Address
	input wire logic row_strobe_n, // Row
	input wire logic col_strobe_n, // Column
	input wire logic write_enable_n, // Write
	input wire logic output_enable_n, // Enable
	input wire logic [3:0] dq_in, // Pin level
	output logic [3:0] dq_out, // Read data
	output logic dq_drv, // Drives pins
	output int cbr_cnt // Refreshes seen
);
	logic [3:0] mem [int];
	logic [8:0] row;
	logic [8:0] col;
	logic [8:0] ctr = 9'h000;
	logic cbr = 1'b0;
	logic wr = 1'b0;
	initial
	begin
		dq_drv = 1'b0;
		cbr_cnt = 0;
	end
	always @(negedge row_strobe_n)
	begin
		cbr = !col_strobe_n;
		if (cbr)
		begin
			ctr = ctr + 9'h001;
			cbr_cnt++;
		end
		else
			row = mux_addr;
	end
	always @(negedge col_strobe_n)
		if (!row_strobe_n && !cbr)
		begin
			col = mux_addr;
			wr = !write_enable_n;
			if (wr)
				mem[{row, col}] = dq_in;
		end
	always @(negedge write_enable_n)
		if (!row_strobe_n && !col_strobe_n && !cbr && !wr)
		begin
			wr = 1'b1;
			mem[{row, col}] = dq_in;
		end
	// Answer lags the later strobe, as a slow part would
	always @(negedge col_strobe_n or negedge output_enable_n)
	begin
		#(ACC_NS);
		if (!col_strobe_n && !output_enable_n && !row_strobe_n && !wr && !cbr)
		begin
			dq_out = mem[{row, col}];
			dq_drv = 1'b1;
		end
	end
	always @(posedge col_strobe_n or posedge output_enable_n)
		dq_drv = 1'b0;
endmodule

// ==== testbench/page_mode_dram_access_tb_top.sv ====
/* Self-checking bench for dram_host with a DRAM model.
 * Inputs change on the falling clock edge; ce is tied high. */
`timescale 1ns/10ps
module page_mode_dram_access_tb_top;
	import dram_host_pkg::*;
	localparam int RI = 200;
	logic clk = 0, rst = 1, ce = 1, req_valid = 0, req_write = 0;
	logic [17:0] req_addr = 0;
	nibble_t req_wdata = 0, rd_data, data_out, pins, last_v = 0, dq_out;
	logic req_ready, rd_valid, init_done, row_strobe_n, col_strobe_n;
	logic write_enable_n, output_enable_n, data_oe_n, dq_drv;
	logic [8:0] mux_addr;
	int cbr_cnt, miscompares = 0, checked = 0, clash = 0, cyc = 0, c0 = 0;
	int unsigned seed = 93344;
	nibble_t ref_mem [int];
	nibble_t exp_q [$];
	logic [17:0] addrs [$];
	dram_host #(.POWERUP_CYCLES(20), .REFRESH_INTERVAL(RI)) dut_u (.clk(clk), .rst(rst),
		.ce(ce), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
		.init_done(init_done), .mux_addr(mux_addr), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
		.output_enable_n(output_enable_n), .data_in(pins), .data_out(data_out),
		.data_oe_n(data_oe_n));
	dram_dev_model mdl_u (.mux_addr(mux_addr), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
		.output_enable_n(output_enable_n), .dq_in(pins), .dq_out(dq_out),
		.dq_drv(dq_drv), .cbr_cnt(cbr_cnt));
	// Released pins show the inverse of the last level
	always @(data_oe_n, data_out, dq_drv, dq_out)
	begin
		pins = !data_oe_n ? data_out : dq_drv ? dq_out : ~last_v;
		last_v = pins;
	end
	initial
		forever #2 clk = ~clk;
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("unexpected %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic req(input logic w, input logic [17:0] a, input nibble_t d);
		int n;
		n = 0;
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		check("ready", n < 3000, 1);
		check("init", init_done, 1);
		if (w)
			ref_mem[a] = d;
		else
			exp_q.push_back(ref_mem[a]);
		@(negedge clk);
		req_valid = 1'b0;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (!data_oe_n && dq_drv)
			clash++;
		if (rd_valid === 1'b1)
		begin
			check("pending", exp_q.size() != 0, 1);
			if (exp_q.size() != 0)
				check("rd_data", rd_data, exp_q.pop_front());
		end
	end
	initial
	begin
		#80000;
		miscompares++;
		complete_run();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check("ready", req_ready, 0);
		check("init", init_done, 0);
		wait (init_done === 1'b1);
		c0 = cyc;
		check("cbr", cbr_cnt >= 8, 1);
		addrs.push_back(18'h00000);
		addrs.push_back(18'h3FFFF);
		repeat (22)
			addrs.push_back(18'(xs()));
		foreach (addrs[i])
		begin
			req(1'b1, addrs[i], 4'(xs()));
			if (i % 4 == 0)
				req(1'b0, addrs[i], 4'(xs()));
		end
		for (int i = addrs.size() - 1; i >= 0; i--)
			req(1'b0, addrs[i], 4'(xs()));
		repeat (60) @(posedge clk);
		check("left", exp_q.size(), 0);
		check("refresh", cbr_cnt >= 7 + (cyc - c0) / RI, 1);
		check("clash", clash, 0);
		complete_run();
	end
endmodule
